/* common/two_wire_slave_map.svh */
// constants of the two-wire register access slave
`ifndef TWO_WIRE_SLAVE_MAP_SVH
`define TWO_WIRE_SLAVE_MAP_SVH

// ----------------------------------------------------------------
// slave address and register space
// ----------------------------------------------------------------
`define SLAVE_ADDR        7'h4C
`define REG_ADDR_MAX      8'hEE
`define REG_ADDR_RESET    8'h00

// ----------------------------------------------------------------
// bit counting
// ----------------------------------------------------------------
`define BYTE_BITS         4'h8
`define LAST_TX_BIT       4'h7

// ----------------------------------------------------------------
// line filtering and idle levels
// ----------------------------------------------------------------
`define FILTER_CYCLES     3
`define LINE_IDLE         1'b1

`endif

/* common/two_wire_slave_pkg.sv */
// types of the two-wire register access slave
package two_wire_slave_pkg;

  typedef enum logic [3:0] {
    IDLE,
    RX_ADDR,
    ACK_ADDR,
    RX_REG,
    ACK_REG,
    RX_DATA,
    ACK_DATA,
    TX_DATA,
    RX_MACK,
    TX_LOAD,
    IGNORE
  } bus_state_t;

endpackage : two_wire_slave_pkg

/* dv/bus_master_model.sv */
// behavioural two-wire bus master facing the slave
`timescale 1ns/1ns

module bus_master_model (
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_m,
  output logic      hold_fault
);
  // ----------------------------------------------------------------
  // bus phases, clock stands high between frames
  // ----------------------------------------------------------------
  initial begin
    scl        = 1'b1;
    sda_m      = 1'b1;
    hold_fault = 1'b0;
  end

  // works from idle and as a repeated start
  task automatic start_cond();
    sda_m = 1'b1;
    #40 scl = 1'b1;
    #80 sda_m = 1'b0;
    #80 scl = 1'b0;
    #40;
  endtask : start_cond

  task automatic stop_cond();
    sda_m = 1'b0;
    #40 scl = 1'b1;
    #80 sda_m = 1'b1;
    #80;
  endtask : stop_cond

  // data moves mid low phase only; line sampled twice while high
  task automatic put_bit(input logic b, output logic r);
    logic r_late;
    sda_m = b;
    #40 scl = 1'b1;
    #10 r = sda_line;
    #60 r_late = sda_line;
    if (r_late !== r) hold_fault = 1'b1;
    #10 scl = 1'b0;
    #40;
  endtask : put_bit

  task automatic put_byte(input logic [7:0] d, input logic ack_in,
                          output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
    put_bit(ack_in, ack);
  endtask : put_byte
endmodule : bus_master_model

/* dv/testbench.sv */
// self-checking bench for the two-wire register access slave
`timescale 1ns/1ns

module testbench;
  localparam logic [7:0] top_addr = 8'hEE;
  logic        clock;
  logic        reset;
  logic        address_select_pin;
  logic [7:0]  rd_data;
  logic        sda_out;
  logic        sda_oe_n;
  logic [7:0]  reg_addr;
  logic        wr_strobe;
  logic [7:0]  wr_data;
  logic        scl;
  logic        sda_m;
  logic        hold_fault;
  wire         sda_line;
  logic [7:0]  mem [256];
  logic [15:0] expect_q [$];
  logic [6:0]  own_addr;
  logic [7:0]  base;
  int          miscompares;
  int          tests_run;
  int          cycles;

  // ----------------------------------------------------------------
  // wiring, clock, register file model and watchers
  // ----------------------------------------------------------------
  // pull-up: line is low only where some party pulls it
  assign sda_line = sda_m & (sda_oe_n | sda_out);

  two_wire_register_access_slave #(.ADDR_MAX(top_addr), .STABLE(3)) dut_u (
    .clock              (clock),
    .reset              (reset),
    .scl_pin            (scl),
    .sda_in             (sda_line),
    .sda_out            (sda_out),
    .sda_oe_n           (sda_oe_n),
    .address_select_pin (address_select_pin),
    .reg_addr           (reg_addr),
    .wr_strobe          (wr_strobe),
    .wr_data            (wr_data),
    .rd_data            (rd_data)
  );

  bus_master_model master_u (
    .sda_line   (sda_line),
    .scl        (scl),
    .sda_m      (sda_m),
    .hold_fault (hold_fault)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  always @(negedge clock) begin
    rd_data <= mem[reg_addr];
    if (wr_strobe === 1'b1) begin
      check({reg_addr, wr_data},
            (expect_q.size() != 0) ? expect_q.pop_front() : 16'hXXXX);
      mem[reg_addr] = wr_data;
    end
  end

  // hang guard sized well above the whole run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // bus transactions
  // ----------------------------------------------------------------
  task automatic probe(input logic [6:0] addr, input logic want);
    logic [7:0] r;
    logic       k;
    master_u.start_cond();
    master_u.put_byte({addr, 1'b0}, 1'b1, r, k);
    check(16'(k), 16'(!want));
    master_u.stop_cond();
    $display("probe of %h done", addr);
  endtask : probe

  task automatic write_run(input logic [7:0] b, input int n,
                           input logic ok);
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic       k;
    master_u.start_cond();
    master_u.put_byte({own_addr, 1'b0}, 1'b1, r, k);
    check(16'(k), 16'h0000);
    master_u.put_byte(b, 1'b1, r, k);
    check(16'(k), 16'(!ok));
    a = b;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (ok) expect_q.push_back({a, d});
      if (ok && a < top_addr) a++;
      master_u.put_byte(d, 1'b1, r, k);
      check(16'(k), 16'(!ok));
    end
    master_u.stop_cond();
    $display("write run at %h done", b);
  endtask : write_run

  task automatic read_run(input logic [7:0] b, input int n);
    logic [7:0] a;
    logic [7:0] r;
    logic       k;
    master_u.start_cond();
    master_u.put_byte({own_addr, 1'b0}, 1'b1, r, k);
    check(16'(k), 16'h0000);
    master_u.put_byte(b, 1'b1, r, k);
    check(16'(k), 16'h0000);
    master_u.start_cond();
    master_u.put_byte({own_addr, 1'b1}, 1'b1, r, k);
    check(16'(k), 16'h0000);
    a = b;
    for (int i = 0; i < n; i++) begin
      master_u.put_byte(8'hFF, i == n - 1, r, k);
      check({8'h00, r}, {8'h00, mem[a]});
      if (a < top_addr) a++;
    end
    master_u.put_byte(8'hFF, 1'b1, r, k);
    check({8'h00, r}, 16'h00FF);
    master_u.stop_cond();
    $display("read run at %h done", b);
  endtask : read_run

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    address_select_pin = 1'b0;
    own_addr = 7'h4C;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    void'($urandom(32'h55A52BCB));
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    repeat (8) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    check({reg_addr, wr_data}, 16'h0000);
    check({14'h0, wr_strobe, sda_oe_n}, 16'h0001);
    repeat (10) @(negedge clock);
    for (int s = 0; s < 2; s++) begin
      address_select_pin = s[0];
      own_addr = {6'b100110, s[0]};
      repeat (4) @(negedge clock);
      probe(own_addr, 1'b1);
      probe(own_addr ^ 7'h01, 1'b0);
      base = 8'($urandom_range(0, 224));
      write_run(base, 4, 1'b1);
      read_run(base, 4);
    end
    write_run(top_addr - 8'h01, 3, 1'b1);
    read_run(top_addr - 8'h01, 3);
    write_run(top_addr + 8'h01, 2, 1'b0);
    check(16'(hold_fault), 16'h0000);
    check(16'(expect_q.size()), 16'h0000);
    close_out();
  end
endmodule : testbench

/* rtl/bus_condition.sv */
// edge, start and stop detection on the filtered bus lines
`timescale 1ns/1ns
`include "two_wire_slave_map.svh"

module bus_condition (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic scl_level,
  input  wire logic sda_level,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_evt,
  output logic      stop_evt
);

  logic scl_prev;
  logic sda_prev;

  // ----------------------------------------------------------------
  // data moving while the clock stays high is never data
  // ----------------------------------------------------------------
  always_comb begin
    scl_rise  = scl_level && !scl_prev;
    scl_fall  = !scl_level && scl_prev;
    start_evt = scl_level && scl_prev && sda_prev && !sda_level;
    stop_evt  = scl_level && scl_prev && !sda_prev && sda_level;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      scl_prev <= `LINE_IDLE;
      sda_prev <= `LINE_IDLE;
    end else begin
      scl_prev <= scl_level;
      sda_prev <= sda_level;
    end
  end

endmodule : bus_condition

/* rtl/line_filter.sv */
// synchroniser and glitch filter for one bus line
`timescale 1ns/1ns
`include "two_wire_slave_map.svh"

module line_filter #(
  parameter int STABLE = `FILTER_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic line_pin,
  output logic      line_out
);

  localparam int CW = $clog2(STABLE + 1);

  logic          meta;
  logic          sync;
  logic          level;
  logic [CW-1:0] cnt;
  logic          next_sync;
  logic          next_level;
  logic [CW-1:0] next_cnt;

  // ----------------------------------------------------------------
  // a new level is taken only once it has held for STABLE cycles
  // ----------------------------------------------------------------
  always_comb begin
    next_sync  = meta;
    next_level = level;
    next_cnt   = cnt;
    if (sync == level) begin
      next_cnt = '0;
    end else if (cnt == CW'(STABLE - 1)) begin
      next_level = sync;
      next_cnt   = '0;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      meta  <= `LINE_IDLE;
      sync  <= `LINE_IDLE;
      level <= `LINE_IDLE;
      cnt   <= '0;
    end else begin
      meta  <= line_pin;
      sync  <= next_sync;
      level <= next_level;
      cnt   <= next_cnt;
    end
  end

  assign line_out = level;

endmodule : line_filter

/* rtl/two_wire_register_access_slave.sv */
// two-wire serial slave giving a bus master access to control registers
`timescale 1ns/1ns
`include "two_wire_slave_map.svh"

module two_wire_register_access_slave
  import two_wire_slave_pkg::*;
#(
  parameter logic [7:0] ADDR_MAX = `REG_ADDR_MAX,
  parameter int         STABLE   = `FILTER_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       address_select_pin,
  output logic [7:0]      reg_addr,
  output logic            wr_strobe,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);

  // ----------------------------------------------------------------
  // line conditioning
  // ----------------------------------------------------------------
  logic [1:0] line_pin;
  logic [1:0] line_level;
  logic       scl_level;
  logic       sda_level;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_evt;
  logic       stop_evt;

  assign line_pin = {scl_pin, sda_in};

  // both lines get the same treatment before any decode
  for (genvar i = 0; i < 2; i++) begin : g_line
    line_filter #(
      .STABLE   (STABLE)
    ) u_filter (
      .clock    (clock),
      .reset    (reset),
      .line_pin (line_pin[i]),
      .line_out (line_level[i])
    );
  end

  assign scl_level = line_level[1];
  assign sda_level = line_level[0];

  bus_condition u_cond (
    .clock     (clock),
    .reset     (reset),
    .scl_level (scl_level),
    .sda_level (sda_level),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_evt (start_evt),
    .stop_evt  (stop_evt)
  );

  // ----------------------------------------------------------------
  // address select pin, caught through two flops
  // ----------------------------------------------------------------
  logic sel_meta;
  logic sel;
  logic next_sel;

  always_comb begin
    next_sel = sel_meta;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sel_meta <= 1'b0;
      sel      <= 1'b0;
    end else begin
      sel_meta <= address_select_pin;
      sel      <= next_sel;
    end
  end

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  bus_state_t state;
  bus_state_t next_state;
  logic [3:0] bits;
  logic [3:0] next_bits;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] next_addr;
  logic [7:0] next_wr_data;
  logic       next_oe_n;
  logic       next_wr;
  logic       rw;
  logic       next_rw;
  logic       addr_match;

  // saturate rather than wrap past the top register
  function automatic logic [7:0] sat_inc(input logic [7:0] a);
    sat_inc = (a >= ADDR_MAX) ? ADDR_MAX : a + 8'h01;
  endfunction : sat_inc

  assign addr_match = shift[7:1] == ((`SLAVE_ADDR & 7'h7E) | {6'h00, sel});

  always_comb begin
    next_state   = state;
    next_bits    = bits;
    next_shift   = shift;
    next_addr    = reg_addr;
    next_wr_data = wr_data;
    next_oe_n    = sda_oe_n;
    next_wr      = 1'b0;
    next_rw      = rw;
    if (stop_evt) begin
      next_state = IDLE;
      next_oe_n  = 1'b1;
    end else if (start_evt) begin
      next_state = RX_ADDR;
      next_bits  = 4'h0;
      next_oe_n  = 1'b1;
    end else begin
      case (state)
        RX_ADDR, RX_REG, RX_DATA: begin
          if (scl_rise && bits != `BYTE_BITS) begin
            next_shift = {shift[6:0], sda_level};
            next_bits  = bits + 4'h1;
          end else if (scl_fall && bits == `BYTE_BITS) begin
            next_bits = 4'h0;
            if (state == RX_ADDR) begin
              if (addr_match) begin
                next_oe_n  = 1'b0;
                next_rw    = shift[0];
                next_state = ACK_ADDR;
              end else begin
                next_state = IGNORE;
              end
            end else if (state == RX_REG) begin
              if (shift <= ADDR_MAX) begin
                next_oe_n  = 1'b0;
                next_addr  = shift;
                next_state = ACK_REG;
              end else begin
                next_state = IGNORE;
              end
            end else begin
              next_oe_n    = 1'b0;
              next_wr      = 1'b1;
              next_wr_data = shift;
              next_state   = ACK_DATA;
            end
          end
        end
        ACK_ADDR: begin
          if (scl_fall) begin
            if (rw) begin
              next_shift = rd_data;
              next_oe_n  = rd_data[7];
              next_bits  = 4'h0;
              next_state = TX_DATA;
            end else begin
              next_oe_n  = 1'b1;
              next_state = RX_REG;
            end
          end
        end
        ACK_REG: begin
          if (scl_fall) begin
            next_oe_n  = 1'b1;
            next_state = RX_DATA;
          end
        end
        ACK_DATA: begin
          if (scl_fall) begin
            next_oe_n  = 1'b1;
            next_addr  = sat_inc(reg_addr);
            next_state = RX_DATA;
          end
        end
        TX_DATA: begin
          // bits leave only on a falling clock edge
          if (scl_fall) begin
            if (bits == `LAST_TX_BIT) begin
              next_oe_n  = 1'b1;
              next_addr  = sat_inc(reg_addr);
              next_state = RX_MACK;
            end else begin
              next_bits  = bits + 4'h1;
              next_shift = {shift[6:0], 1'b0};
              next_oe_n  = shift[6];
            end
          end
        end
        RX_MACK: begin
          if (scl_rise) begin
            next_state = sda_level ? IGNORE : TX_LOAD;
          end
        end
        TX_LOAD: begin
          if (scl_fall) begin
            next_shift = rd_data;
            next_oe_n  = rd_data[7];
            next_bits  = 4'h0;
            next_state = TX_DATA;
          end
        end
        IDLE, IGNORE: begin
          next_oe_n = 1'b1;
        end
        default: begin
          next_state = IDLE;
          next_oe_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state     <= IDLE;
      bits      <= 4'h0;
      shift     <= 8'h00;
      reg_addr  <= `REG_ADDR_RESET;
      wr_data   <= 8'h00;
      sda_oe_n  <= 1'b1;
      wr_strobe <= 1'b0;
      rw        <= 1'b0;
    end else begin
      state     <= next_state;
      bits      <= next_bits;
      shift     <= next_shift;
      reg_addr  <= next_addr;
      wr_data   <= next_wr_data;
      sda_oe_n  <= next_oe_n;
      wr_strobe <= next_wr;
      rw        <= next_rw;
    end
  end

  // open drain: the pad only ever pulls low
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence byte_end_s;
    scl_fall && bits == `BYTE_BITS;
  endsequence

  sequence addr_byte_s;
    state == RX_ADDR ##0 byte_end_s;
  endsequence

  idle_released_a: assert property (
    state == IDLE |-> sda_oe_n)
    else $error("data line driven while idle");

  start_to_addr_a: assert property (
    start_evt && !stop_evt |=> state == RX_ADDR && bits == 4'h0)
    else $error("start not followed by address phase");

  addr_ack_a: assert property (
    addr_byte_s ##0 addr_match |=> !sda_oe_n [*1] ##0 state == ACK_ADDR)
    else $error("own address not acknowledged");

  addr_nack_a: assert property (
    addr_byte_s ##0 !addr_match |=> sda_oe_n && state == IGNORE)
    else $error("foreign address acknowledged");

  reg_reject_a: assert property (
    state == RX_REG ##0 byte_end_s ##0 shift > ADDR_MAX
      |=> sda_oe_n && state == IGNORE)
    else $error("out of range base address acknowledged");

  addr_advance_a: assert property (
    state == ACK_DATA && scl_fall && !start_evt && !stop_evt
      |=> reg_addr == sat_inc($past(reg_addr)))
    else $error("register address did not advance or saturate");

  write_strobe_a: assert property (
    wr_strobe |-> state == ACK_DATA && !sda_oe_n
      && wr_data == $past(shift))
    else $error("write strobe without acknowledged data byte");

  master_nack_a: assert property (
    state == RX_MACK && scl_rise && sda_level
      && !start_evt && !stop_evt |=> state == IGNORE ##1 sda_oe_n)
    else $error("read went on after master did not acknowledge");

  stop_idle_a: assert property (
    stop_evt |=> state == IDLE && sda_oe_n)
    else $error("stop did not return to idle");

  drive_on_low_a: assert property (
    $changed(sda_oe_n) |-> $past(scl_fall || start_evt || stop_evt))
    else $error("data line changed outside clock low");

endmodule : two_wire_register_access_slave
